// ===== rtl/wpr_regs.svh
// Timing counts, message codes and thresholds for the power receiver control block
`ifndef WPR_REGS_SVH
`define WPR_REGS_SVH
`define CLK_HZ            40000000
`define BIT_PERIOD_NS     500000
`define BIT_CYCLES        (`BIT_PERIOD_NS / 25)
`define HALF_CYCLES       (`BIT_CYCLES / 2)
`define HDR_EPT           8'h02
`define RSN_UNKNOWN       8'h00
`define RSN_CHARGE_DONE   8'h01
`define RSN_INT_FAULT     8'h02
`define RSN_OVER_TEMP     8'h03
`define RSN_OVER_CURRENT  8'h05
`define RSN_NO_RESPONSE   8'h08
`define CUR_COMM_KNEE_MA  12'd300
`define CUR_COMM_FIX_MA   12'd400
`define CUR_COMM_ADD_MA   12'd50
`define CUR_FULL_ON_MA    12'd120
`define CUR_FULL_OFF_MA   12'd100
`define FRAME_BITS        4'd11
`endif

// ===== rtl/wpr_pkg.sv
// Types for the power receiver control block
package wpr_pkg;
  typedef enum logic [1:0] {
    RECT_DIODE = 2'b00,
    RECT_HALF  = 2'b01,
    RECT_FULL  = 2'b10
  } rect_mode_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_BITS = 2'b10
  } tx_state_t;
endpackage : wpr_pkg

// ===== rtl/wireless_power_rx_comm_control.sv
// Receiver control: end-of-transfer reasons, bi-phase framer, status, current limit, rectifier modes
//
// Function
// [RULE1] Message is header 0x02 plus reason byte
// [RULE2] Adapter above 3.6 V sends reason 0x00
// [RULE3] Control pin or enables send reason 0x01; the code decodes only enable_sel_a here, enable_sel_b sends nothing
// [RULE4] Die hot or low resistance sends 0x02
// [RULE5] Temperature out of window sends 0x03
// [RULE6] Output above 90% limit sends 0x05
// [RULE7] Reconfigure code 0x07 is never sent
// [RULE8] Rectifier not converging sends reason 0x08
// [RULE9] Current at full limit sends message
// [RULE10] Transmitter stops power on message receipt
// [RULE11] Status low while supply output enabled
// [RULE12] Output disabled until rectifier converges
// [RULE13] Each bit lasts one 0.5 ms period
// [RULE14] One has two transitions, zero one
// [RULE15] Bytes go LSB first in 11-bit frame
// [RULE16] Start zero, odd parity, stop one
// [RULE17] Comm limit 400 mA or current plus 50
// [RULE18] Synchronous rectifier off during start-up
// [RULE19] Half above UVLO, full above 120 mA
// [RULE20] Comm limit only with both enables low
// [RULE21] Parity makes odd count of ones
// [RULE22] Toggle at bit start, mid for ones
// [RULE23] Both modulation switches driven together
`timescale 1ns/1ps
`include "wpr_regs.svh"
module wireless_power_rx_comm_control
(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               adapter_over_3v6,
  input  wire logic               temp_control_pin,
  input  wire logic               enable_sel_a,
  input  wire logic               enable_sel_b,
  input  wire logic               die_over_150c,
  input  wire logic               current_limit_setting,
  input  wire logic               temp_below_hot,
  input  wire logic               temp_above_cold,
  input  wire logic               ctrl_below_100mv,
  input  wire logic               term_variant,
  input  wire logic               ocp_variant,
  input  wire logic               iout_over_90pct,
  input  wire logic               iout_at_limit,
  input  wire logic               rectifier_voltage_conv_fail,
  input  wire logic               rectifier_voltage_converged,
  input  wire logic               rectifier_voltage_uvlo_ok,
  input  wire logic [11:0]        iout_ma,
  input  wire logic [7:0]         pkt_byte,
  input  wire logic               pkt_valid,
  output logic                    pkt_ready,
  output logic                    end_power_transfer_msg,
  output logic [7:0]              ept_reason,
  output logic                    supply_enable,
  output logic                    charge_status_n_out,
  output logic                    charge_status_n_oe,
  output logic                    comm_limit_active,
  output logic [11:0]             comm_limit_ma,
  output wpr_pkg::rect_mode_t     rect_mode,
  output logic                    modulation_switch_a,
  output logic                    modulation_switch_b,
  output logic                    tx_busy
);
  import wpr_pkg::*;

  localparam logic [15:0] BIT_CNT  = 16'(`BIT_CYCLES);
  localparam logic [15:0] HALF_CNT = 16'(`HALF_CYCLES);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] raw_in;
  assign raw_in = {adapter_over_3v6, temp_control_pin, enable_sel_a, enable_sel_b, die_over_150c,
                   current_limit_setting, temp_below_hot, temp_above_cold, ctrl_below_100mv,
                   term_variant, ocp_variant, iout_over_90pct, iout_at_limit,
                   rectifier_voltage_conv_fail, rectifier_voltage_converged,
                   rectifier_voltage_uvlo_ok};

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  logic s_ad, s_ctrl, s_ena, s_enb, s_tj, s_rlow, s_hot, s_cold, s_c100;
  logic s_termv, s_ocpv, s_i90, s_current_limit_setting, s_nconv, s_conv, s_uvlo;
  assign {s_ad, s_ctrl, s_ena, s_enb, s_tj, s_rlow, s_hot, s_cold, s_c100,
          s_termv, s_ocpv, s_i90, s_current_limit_setting, s_nconv, s_conv, s_uvlo} = sync2_r;

  // ----------------------------------------
  // Reason selection
  // ----------------------------------------
  logic       fault_any;
  logic [7:0] reason_nxt;

  always_comb
  begin
    fault_any  = 1'b1;
    reason_nxt = `RSN_UNKNOWN;
    if (s_tj || s_rlow)
      reason_nxt = `RSN_INT_FAULT;                         // [RULE4]
    else if (s_hot || s_cold || s_c100)
      reason_nxt = `RSN_OVER_TEMP;                         // [RULE5]
    else if ((s_termv && s_i90) || (s_ocpv && s_current_limit_setting))
      reason_nxt = `RSN_OVER_CURRENT;                      // [RULE6] [RULE9]
    else if (s_nconv)
      reason_nxt = `RSN_NO_RESPONSE;                       // [RULE8]
    else if (s_ctrl || s_ena)
      reason_nxt = `RSN_CHARGE_DONE;                       // [RULE3]
    else if (s_ad)
      reason_nxt = `RSN_UNKNOWN;                           // [RULE2]
    else
      fault_any = 1'b0;
    // Codes 0x04 and 0x07 are never produced              // [RULE7]
  end

  logic ept_pending_r;
  logic ept_sent_r;
  logic hdr_pending_r;

  always_ff @(posedge clock)
  begin
    if (!resetn)
      ept_reason <= 8'h00;
    else if (fault_any && !ept_pending_r && !ept_sent_r)
      ept_reason <= reason_nxt;
  end

  // ----------------------------------------
  // Supply enable and status output
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
      supply_enable <= 1'b0;
    else
      supply_enable <= s_conv && !fault_any && !ept_sent_r; // [RULE12]
  end

  assign charge_status_n_out = 1'b0;
  assign charge_status_n_oe  = supply_enable;              // [RULE11]

  // ----------------------------------------
  // Communication current limit
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      comm_limit_active <= 1'b0;
      comm_limit_ma     <= `CUR_COMM_FIX_MA;
    end
    else
    begin
      comm_limit_active <= !s_ena && !s_enb;               // [RULE20]
      if (iout_ma > `CUR_COMM_KNEE_MA)
        comm_limit_ma <= iout_ma + `CUR_COMM_ADD_MA;       // [RULE17]
      else
        comm_limit_ma <= `CUR_COMM_FIX_MA;                 // [RULE17]
    end
  end

  // ----------------------------------------
  // Rectifier mode sequencing
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
      rect_mode <= RECT_DIODE;                             // [RULE18]
    else if (!s_uvlo)
      rect_mode <= RECT_DIODE;                             // [RULE18]
    else
      case (rect_mode)
        RECT_DIODE: rect_mode <= RECT_HALF;                // [RULE19]
        RECT_HALF:  if (iout_ma > `CUR_FULL_ON_MA) rect_mode <= RECT_FULL;  // [RULE19]
        RECT_FULL:  if (iout_ma < `CUR_FULL_OFF_MA) rect_mode <= RECT_HALF; // [RULE19]
        default:    rect_mode <= RECT_DIODE;
      endcase
  end

  // ----------------------------------------
  // Two-entry byte buffer
  // ----------------------------------------
  logic [7:0] buf_mem [0:1];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] count_r;
  logic       buf_pop;
  logic       buf_push;

  assign pkt_ready = (count_r != 2'd2) && !ept_pending_r && !hdr_pending_r;
  assign buf_push  = pkt_valid && pkt_ready;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'd0;
    end
    else
    begin
      if (buf_push)
      begin
        buf_mem[wr_ptr_r] <= pkt_byte;
        wr_ptr_r          <= !wr_ptr_r;
      end
      if (buf_pop)
        rd_ptr_r <= !rd_ptr_r;
      count_r <= count_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ----------------------------------------
  // End-of-transfer sequencing
  // ----------------------------------------
  logic       tx_start;
  logic [7:0] tx_byte;
  tx_state_t  tx_state_r;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ept_pending_r <= 1'b0;
      hdr_pending_r <= 1'b0;
      ept_sent_r    <= 1'b0;
    end
    else
    begin
      if (fault_any && !ept_pending_r && !ept_sent_r)
      begin
        ept_pending_r <= 1'b1;
        hdr_pending_r <= 1'b1;
      end
      else if (tx_start && hdr_pending_r && count_r == 2'd0)
        hdr_pending_r <= 1'b0;
      else if (tx_start && ept_pending_r && count_r == 2'd0)
      begin
        ept_pending_r <= 1'b0;
        ept_sent_r    <= 1'b1;
      end
      if (!fault_any && !ept_pending_r && tx_state_r == TX_IDLE)
        ept_sent_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      end_power_transfer_msg <= 1'b0;
    else
      end_power_transfer_msg <= ept_pending_r || (ept_sent_r && tx_busy);
  end

  // Priority: queued bytes drain, then header, then reason
  always_comb
  begin
    tx_start = 1'b0;
    buf_pop  = 1'b0;
    tx_byte  = 8'h00;
    if (tx_state_r == TX_IDLE)
    begin
      if (count_r != 2'd0)
      begin
        tx_start = 1'b1;
        buf_pop  = 1'b1;
        tx_byte  = buf_mem[rd_ptr_r];
      end
      else if (hdr_pending_r)
      begin
        tx_start = 1'b1;
        tx_byte  = `HDR_EPT;                               // [RULE1]
      end
      else if (ept_pending_r)
      begin
        tx_start = 1'b1;
        tx_byte  = ept_reason;                             // [RULE1]
      end
    end
  end

  // ----------------------------------------
  // Frame serialiser and bi-phase encoder
  // ----------------------------------------
  function automatic logic odd_parity(input logic [7:0] d);
    odd_parity = ~(^d);                                    // [RULE21]
  endfunction : odd_parity

  logic [10:0] shift_r;
  logic [3:0]  bit_idx_r;
  logic [15:0] cyc_r;
  logic        mod_r;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      tx_state_r <= TX_IDLE;
      shift_r    <= 11'h7ff;
      bit_idx_r  <= 4'd0;
      cyc_r      <= 16'd0;
      mod_r      <= 1'b0;
    end
    else
      case (tx_state_r)
        TX_IDLE:
        begin
          if (tx_start)
          begin
            shift_r    <= {1'b1, odd_parity(tx_byte), tx_byte, 1'b0}; // [RULE15] [RULE16]
            bit_idx_r  <= 4'd0;
            cyc_r      <= 16'd0;
            tx_state_r <= TX_LOAD;
          end
        end
        TX_LOAD:
        begin
          mod_r      <= !mod_r;                            // [RULE22] [RULE14]
          cyc_r      <= 16'd1;
          tx_state_r <= TX_BITS;
        end
        TX_BITS:
        begin
          if (cyc_r == HALF_CNT && shift_r[0])
            mod_r <= !mod_r;                               // [RULE22] [RULE14]
          if (cyc_r == BIT_CNT - 16'd1)                    // [RULE13]
          begin
            shift_r <= {1'b1, shift_r[10:1]};              // [RULE15]
            if (bit_idx_r == `FRAME_BITS - 4'd1)
              tx_state_r <= TX_IDLE;
            else
            begin
              bit_idx_r  <= bit_idx_r + 4'd1;
              tx_state_r <= TX_LOAD;
            end
            cyc_r <= 16'd0;
          end
          else
            cyc_r <= cyc_r + 16'd1;
        end
        default: tx_state_r <= TX_IDLE;
      endcase
  end

  assign tx_busy             = (tx_state_r != TX_IDLE);
  assign modulation_switch_a = mod_r;                      // [RULE23]
  assign modulation_switch_b = mod_r;                      // [RULE23]

endmodule : wireless_power_rx_comm_control

// ===== bench/wpr_ctrl_props.sv
// Port checks for the receiver control block
`timescale 1ns/1ps
module wpr_ctrl_props
  import wpr_pkg::*;
(
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic                rectifier_voltage_converged,
  input wire logic                rectifier_voltage_uvlo_ok,
  input wire logic                enable_sel_a,
  input wire logic                enable_sel_b,
  input wire logic [11:0]         iout_ma,
  input wire logic                end_power_transfer_msg,
  input wire logic [7:0]          ept_reason,
  input wire logic                supply_enable,
  input wire logic                charge_status_n_out,
  input wire logic                charge_status_n_oe,
  input wire logic                comm_limit_active,
  input wire logic [11:0]         comm_limit_ma,
  input wire wpr_pkg::rect_mode_t rect_mode,
  input wire logic                modulation_switch_a,
  input wire logic                modulation_switch_b
);
  logic        prev_r;
  logic [15:0] gap_r;
  wire         charge_status_n = modulation_switch_a != prev_r;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prev_r <= 1'b0;
      gap_r  <= 16'hffff;
    end
    else
    begin
      prev_r <= modulation_switch_a;
      gap_r  <= charge_status_n ? 16'h0001 : (gap_r == 16'hffff ? gap_r : gap_r + 16'h0001);
    end
  end
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence load_up_s;
    (rectifier_voltage_uvlo_ok && iout_ma > 12'd120) [*8];
  endsequence
  sequence load_down_s;
    (iout_ma < 12'd100) [*3];
  endsequence
  a_switch_pair: assert property (modulation_switch_a == modulation_switch_b)
    else $error("modulation switches differ");
  a_status_pin: assert property (charge_status_n_oe == supply_enable && !charge_status_n_out)
    else $error("status pin does not follow supply");
  a_supply_gate: assert property (!rectifier_voltage_converged [*4] |=> !supply_enable)
    else $error("supply on without convergence");
  a_reason_codes: assert property (end_power_transfer_msg |->
    ept_reason inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08}) else $error("bad reason code");
  a_diode_start: assert property (!rectifier_voltage_uvlo_ok [*4] |=> rect_mode == RECT_DIODE)
    else $error("rectifier active before lockout cleared");
  a_full_above: assert property (load_up_s |=> rect_mode == RECT_FULL)
    else $error("full mode missing under load");
  a_half_below: assert property (load_down_s |=> rect_mode != RECT_FULL)
    else $error("full mode kept at light load");
  a_limit_value: assert property ($past(resetn) |-> comm_limit_ma ==
    ($past(iout_ma) > 12'd300 ? $past(iout_ma) + 12'd50 : 12'd400)) else $error("comm limit wrong");
  a_limit_on: assert property ((!enable_sel_a && !enable_sel_b) [*4] |=> comm_limit_active)
    else $error("comm limit not active");
  a_toggle_gap: assert property (charge_status_n |-> gap_r >= 16'd10000)
    else $error("modulation toggles too close");
endmodule : wpr_ctrl_props

// ===== bench/wpr_tx_decoder.sv
// Transmitter side decoder of the load-modulation bit stream
`timescale 1ns/1ps
module wpr_tx_decoder
(
  input  wire logic   clock,
  input  wire logic   resetn,
  input  wire logic   coil_mod,
  output logic [3:0]  bit_count,
  output logic [10:0] bits
);
  logic        prev_r;
  logic        q1_r;
  logic        active_r;
  logic [14:0] cnt_r;
  always_ff @(posedge clock)
  begin
    prev_r <= coil_mod;
    if (!resetn)
    begin
      active_r  <= 1'b0;
      bit_count <= 4'h0;
      bits      <= 11'h000;
    end
    else if (!active_r)
    begin
      active_r <= coil_mod != prev_r;
      cnt_r    <= 15'h0000;
    end
    else
    begin
      cnt_r <= (cnt_r == 15'd19999) ? 15'h0000 : cnt_r + 15'h0001;
      if (cnt_r == 15'd5000)
        q1_r <= coil_mod;
      if (cnt_r == 15'd15000)
      begin
        bits[bit_count] <= coil_mod ^ q1_r;
        bit_count       <= bit_count + 4'h1;
        active_r        <= bit_count != 4'd10;
      end
    end
  end
endmodule : wpr_tx_decoder

// ===== bench/wireless_power_rx_comm_control_tb.sv
// Self-checking bench for the receiver control block
`timescale 1ns/1ps
module wireless_power_rx_comm_control_tb;
  import wpr_pkg::*;
  logic clock, resetn, adapter_over_3v6, temp_control_pin, enable_sel_a, enable_sel_b, die_over_150c;
  logic current_limit_setting, temp_below_hot, temp_above_cold, ctrl_below_100mv, term_variant;
  logic ocp_variant, iout_over_90pct, iout_at_limit, rectifier_voltage_conv_fail;
  logic rectifier_voltage_converged, rectifier_voltage_uvlo_ok, pkt_valid, pkt_ready;
  logic end_power_transfer_msg, supply_enable, charge_status_n_out, charge_status_n_oe;
  logic comm_limit_active, modulation_switch_a, modulation_switch_b, tx_busy;
  logic [11:0] iout_ma, comm_limit_ma;
  logic [7:0]  pkt_byte, ept_reason;
  rect_mode_t  rect_mode;
  logic [3:0]  nbits;
  logic [10:0] bits;
  int          bad_count;
  int          total_checks;
  wireless_power_rx_comm_control uut (.*);
  wpr_tx_decoder tx (.clock(clock), .resetn(resetn), .coil_mod(modulation_switch_a), .bit_count(nbits), .bits(bits));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic push(input logic [7:0] b);
    int k = 0;
    pkt_byte  = b;
    pkt_valid = 1'b1;
    while (pkt_ready !== 1'b1 && k < 100)
    begin
      tick(1);
      k++;
    end
    if (pkt_ready !== 1'b1)
      bad_count++;
    tick(1);
  endtask : push
  task automatic try_reason(input logic [12:0] cause, input logic exp_msg, input logic [7:0] exp_code);
    resetn = 1'b0;
    {adapter_over_3v6, temp_control_pin, enable_sel_a, die_over_150c, current_limit_setting,
     temp_below_hot, temp_above_cold, ctrl_below_100mv, term_variant, ocp_variant, iout_over_90pct,
     iout_at_limit, rectifier_voltage_conv_fail} = '0;
    tick(3);
    resetn = 1'b1;
    {adapter_over_3v6, temp_control_pin, enable_sel_a, die_over_150c, current_limit_setting,
     temp_below_hot, temp_above_cold, ctrl_below_100mv, term_variant, ocp_variant, iout_over_90pct,
     iout_at_limit, rectifier_voltage_conv_fail} = cause;
    tick(6);
    check("cause msg", end_power_transfer_msg, exp_msg);
    check("cause code", ept_reason, exp_code);
    check("cause busy", tx_busy, exp_msg);
  endtask : try_reason
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Tests need about 80150 cycles
  initial
  begin
    #(100000 * 25);
    bad_count++;
    wrap_up();
  end
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    resetn = 1'b0;
    {adapter_over_3v6, temp_control_pin, enable_sel_a, enable_sel_b, die_over_150c, current_limit_setting,
     temp_below_hot, temp_above_cold, ctrl_below_100mv, term_variant, ocp_variant, iout_over_90pct,
     iout_at_limit, rectifier_voltage_conv_fail, rectifier_voltage_converged, rectifier_voltage_uvlo_ok,
     pkt_valid} = '0;
    iout_ma = 12'h000;
    pkt_byte = 8'h00;
    tick(2);
    check("ready", pkt_ready, 1);
    check("limit", comm_limit_ma, 12'd400);
    resetn = 1'b1;
    tick(6);
    check("mode", rect_mode, RECT_DIODE);
    check("supply", supply_enable, 0);
    check("limit on", comm_limit_active, 1);
    rectifier_voltage_uvlo_ok = 1'b1;
    tick(6);
    check("half", rect_mode, RECT_HALF);
    iout_ma = 12'd121;
    tick(3);
    check("full", rect_mode, RECT_FULL);
    iout_ma = 12'd100;
    tick(3);
    check("held", rect_mode, RECT_FULL);
    iout_ma = 12'd99;
    tick(3);
    check("back", rect_mode, RECT_HALF);
    iout_ma = 12'd300;
    tick(2);
    check("knee", comm_limit_ma, 12'd400);
    iout_ma = 12'd301;
    tick(2);
    check("track", comm_limit_ma, 12'd351);
    enable_sel_b = 1'b1;
    tick(6);
    check("limit off", comm_limit_active, 0);
    $display("test modes done");
    rectifier_voltage_converged = 1'b1;
    tick(6);
    check("supply", supply_enable, 1);
    check("status", {charge_status_n_oe, charge_status_n_out}, 2'h2);
    push(8'h03);
    push(8'h55);
    push(8'haa);
    pkt_valid = 1'b0;
    check("full buf", pkt_ready, 0);
    {adapter_over_3v6, temp_control_pin, enable_sel_a, die_over_150c, current_limit_setting,
     temp_below_hot, temp_above_cold, ctrl_below_100mv, term_variant, ocp_variant, iout_over_90pct,
     iout_at_limit, rectifier_voltage_conv_fail} = '1;
    tick(6);
    check("msg", end_power_transfer_msg, 1);
    check("reason", ept_reason, 8'h02);
    check("supply", supply_enable, 0);
    check("status off", charge_status_n_oe, 0);
    check("busy", tx_busy, 1);
    $display("test message done");
    {rectifier_voltage_converged, rectifier_voltage_uvlo_ok} = 2'h0;
    tick(6);
    check("diode", rect_mode, RECT_DIODE);
    tick(79994);
    check("bits", nbits, 4);
    check("frame", bits[3:0], 4'h6);
    $display("test stream done");
    try_reason(13'h1000, 1, 8'h00);
    try_reason(13'h0800, 1, 8'h01);
    try_reason(13'h0400, 1, 8'h01);
    try_reason(13'h0100, 1, 8'h02);
    try_reason(13'h0040, 1, 8'h03);
    try_reason(13'h0020, 1, 8'h03);
    try_reason(13'h0014, 1, 8'h05);
    try_reason(13'h0004, 0, 8'h00);
    try_reason(13'h000a, 1, 8'h05);
    try_reason(13'h0001, 1, 8'h08);
    try_reason(13'h0081, 1, 8'h03);
    $display("test causes done");
    wrap_up();
  end
endmodule : wireless_power_rx_comm_control_tb
bind wireless_power_rx_comm_control wpr_ctrl_props chk (.*);
